// *** sim/sadc_afe_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// -------------------------------
// analog mux and comparator
// -------------------------------
module sadc_afe_model (
	input wire logic [2:0] analog_inputs_sel,
	input wire logic [7:0] dac_code,
	output logic comparator_hi
);
	import sadc_pkg::*;
	logic [7:0] level; // input level, half a code above this
	// one fixed level per channel through the mux
	always_comb begin
		level = 8'h11 * analog_inputs_sel + 8'h0E;
		comparator_hi = level >= dac_code;
	end
endmodule
`default_nettype wire

// *** sim/sadc_sequencer_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
// -------------------------------
// sequencer port checker
// -------------------------------
module sadc_sequencer_monitor #(
	parameter int STEP_LEN = sadc_pkg::STEP_CYCLES
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [2:0] analog_inputs_sel,
	input wire logic analog_sample,
	input wire logic [7:0] dac_code,
	input wire logic conversion_done_irq
);
	import sadc_pkg::*;
	int samp_cnt; // cycles spent in the sample step
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// length of the current sample step
	always_ff @(posedge ref_clk) begin
		if (sys_rst) samp_cnt <= 0;
		else if (analog_sample) samp_cnt <= samp_cnt + 1;
		else samp_cnt <= 0;
	end
	done_pulse_a: assert property (conversion_done_irq |=> !conversion_done_irq)
		else $error("done pulse longer than one cycle");
	done_gap_a: assert property ($fell(conversion_done_irq) |-> !conversion_done_irq [*8])
		else $error("done pulses too close");
	mux_reset_a: assert property ($fell(sys_rst) |-> analog_inputs_sel == 3'h0)
		else $error("mux not on first input after reset");
	mux_hold_a: assert property (analog_sample && $past(analog_sample) |-> $stable(analog_inputs_sel))
		else $error("mux moved while sampling");
	sample_len_a: assert property ($fell(analog_sample) |-> samp_cnt == STEP_LEN)
		else $error("sample step length wrong");
	first_trial_a: assert property ($fell(analog_sample) |-> ##[0:1] dac_code == 8'h80)
		else $error("first trial code wrong");
	bit_steps_a: assert property ($fell(analog_sample) |-> !analog_sample [*8])
		else $error("bit steps cut short");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
endmodule
bind sadc_sequencer sadc_sequencer_monitor #(.STEP_LEN(STEP_LEN)) u_mon (
	.ref_clk, .sys_rst, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.analog_inputs_sel, .analog_sample, .dac_code, .conversion_done_irq);
`default_nettype wire

// *** sim/sadc_sequencer_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module sadc_sequencer_tb;
	import sadc_pkg::*;
	// -------------------------------
	// stimulus and observed signals
	// -------------------------------
	logic ref_clk = 1'h0, sys_rst = 1'h1, ext_trigger_input = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_bready = 1'h1, s_axi_rready = 1'h1; // always ready for answers
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic analog_sample, comparator_hi, conversion_done_irq, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, rv;
	logic [2:0] analog_inputs_sel;
	logic [7:0] dac_code;
	int mismatches = 0, n_checks = 0, n_done = 0, n_samp = 0, s0, s1;
	sadc_sequencer #(.STEP_LEN(4)) dut (.ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.analog_inputs_sel, .analog_sample, .dac_code, .comparator_hi,
		.ext_trigger_input, .conversion_done_irq, .irq);
	sadc_afe_model afe (.analog_inputs_sel, .dac_code, .comparator_hi);
	// clock and event counters
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (conversion_done_irq) n_done++;
		if ($rose(analog_sample)) n_samp++;
	end
	// -------------------------------
	// shared tasks
	// -------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [31:0] res(input logic [2:0] c);
		return {21'h0, c, 8'h11 * c + 8'h0E};
	endfunction
	// address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, na, nw;
		logic [1:0] br;
		ta = 1'h0;
		tw = 1'h0;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		while (!(ta && tw)) begin
			@(negedge ref_clk);
			na = !ta && s_axi_awready;
			nw = !tw && s_axi_wready;
			@(posedge ref_clk);
			if (na) s_axi_awvalid <= 1'h0;
			if (nw) s_axi_wvalid <= 1'h0;
			ta = ta || na;
			tw = tw || nw;
		end
		do @(negedge ref_clk); while (!s_axi_bvalid);
		br = s_axi_bresp;
		@(posedge ref_clk);
		check("bresp", 32'h0, {30'h0, br});
	endtask
	task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [1:0] rr;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do @(negedge ref_clk); while (!s_axi_arready);
		@(posedge ref_clk);
		s_axi_arvalid <= 1'h0;
		do @(negedge ref_clk); while (!s_axi_rvalid);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		@(posedge ref_clk);
		check(what, exp, rv);
		check("rresp", 32'h0, {30'h0, rr});
	endtask
	task automatic wait_done;
		do @(negedge ref_clk); while (!conversion_done_irq);
	endtask
	// stop between bit steps, never inside a sample step
	task automatic stop_conv;
		@(negedge analog_sample);
		wr(MODE_OFFS, 32'h0);
	endtask
	// -------------------------------
	// scenarios
	// -------------------------------
	task automatic t_reset;
		rc("mode", MODE_OFFS, 32'h0);
		rc("state", STATE_OFFS, 32'h0);
		check("mux", 32'h0, {29'h0, analog_inputs_sel});
		check("irq", 32'h0, {31'h0, irq});
	endtask
	task automatic t_scan;
		wr(MASK_OFFS, 32'h1);
		wr(MODE_OFFS, 32'h35);
		for (int i = 0; i < 5; i++) begin
			wait_done();
			rc("scan result", RESULT_OFFS, res(3'(i % 4)));
		end
		rc("status", STAT_OFFS, 32'h1);
		check("irq", 32'h1, {31'h0, irq});
		stop_conv();
		wr(STAT_OFFS, 32'h3);
		check("irq", 32'h0, {31'h0, irq});
	endtask
	task automatic t_select;
		s0 = n_done;
		wr(MODE_OFFS, 32'h51);
		s1 = n_samp;
		wait (n_samp >= s1 + 3);
		check("done count", s0, n_done);
		rc("select result", RESULT_OFFS, res(3'h5));
		rc("status", STAT_OFFS, 32'h0);
		stop_conv();
	endtask
	task automatic t_hw;
		wr(MASK_OFFS, 32'h3);
		wr(MODE_OFFS, 32'h23);
		s0 = n_samp;
		repeat (20) @(posedge ref_clk);
		check("no start", s0, n_samp);
		rc("armed state", STATE_OFFS, 32'h51);
		ext_trigger_input <= 1'h1;
		repeat (4) @(posedge ref_clk);
		ext_trigger_input <= 1'h0;
		wait_done();
		wait_done();
		rc("hw result", RESULT_OFFS, res(3'h2));
		rc("status", STAT_OFFS, 32'h3);
		wr(MASK_OFFS, 32'h0);
		check("masked irq", 32'h0, {31'h0, irq});
		wr(RESULT_OFFS, 32'h0);
		rc("result kept", RESULT_OFFS, res(3'h2));
		rc("unmapped", 8'h14, 32'h0);
		stop_conv();
	endtask
	// reset after a stop puts the mux back on the first input
	task automatic t_rst2;
		check("mux before", 32'h2, {29'h0, analog_inputs_sel});
		@(posedge ref_clk);
		sys_rst <= 1'h1;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'h0;
		@(posedge ref_clk);
		check("mux after", 32'h0, {29'h0, analog_inputs_sel});
		rc("mode after", MODE_OFFS, 32'h0);
		rc("state after", STATE_OFFS, 32'h0);
	endtask
	// hardware start with scan over inputs 0 and 1
	task automatic t_hw_scan;
		wr(MODE_OFFS, 32'h17);
		ext_trigger_input <= 1'h1;
		repeat (4) @(posedge ref_clk);
		ext_trigger_input <= 1'h0;
		wait_done();
		rc("hw scan first", RESULT_OFFS, res(3'h0));
		wait_done();
		rc("hw scan next", RESULT_OFFS, res(3'h1));
		wait_done();
		rc("hw scan wrap", RESULT_OFFS, res(3'h0));
		stop_conv();
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'h0;
		t_reset();
		t_scan();
		t_select();
		t_hw();
		t_rst2();
		t_hw_scan();
		end_of_test();
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		end_of_test();
	end
endmodule
`default_nettype wire

// *** verilog/sadc_pkg.sv ***
`default_nettype none
package sadc_pkg;
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] MODE_OFFS = 8'h00; // converter_mode_reg
	localparam logic [7:0] RESULT_OFFS = 8'h04; // conversion_result_reg
	localparam logic [7:0] STAT_OFFS = 8'h08; // sticky event status, w1c
	localparam logic [7:0] MASK_OFFS = 8'h0C; // interrupt mask
	localparam logic [7:0] STATE_OFFS = 8'h10; // live converter state
	// ----------------------------------------
	// mode register field positions
	// ----------------------------------------
	localparam int MODE_RUN_POS = 0; // run / start bit
	localparam int MODE_HW_POS = 1; // 1: external trigger start
	localparam int MODE_SCAN_POS = 2; // scan_select_bit: 1 scan, 0 select
	localparam int MODE_CHAN_POS = 4; // channel / last scanned channel
	// ----------------------------------------
	// event bits in status and mask
	// ----------------------------------------
	localparam int EV_DONE_POS = 0; // result transferred
	localparam int EV_TRIG_POS = 1; // external trigger seen
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [31:0] MODE_RST = 32'h0000_0000;
	localparam logic [1:0] MASK_RST = 2'h0;
	localparam logic [2:0] CHAN_RST = 3'h0; // first analog input after reset
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CONV_TIME_NS = 30000; // one conversion, about 30 us
	localparam int CLK_PERIOD_NS = 8; // ref_clk at 125 MHz
	localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS; // longest time, rounds down
	localparam int CONV_STEPS = 9; // one sample step plus eight bit steps
	localparam int STEP_CYCLES = CONV_CYCLES / CONV_STEPS; // cycles per step
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] chan; // selected or last scanned channel
		logic scan; // scan_select_bit
		logic hw_start; // start source
		logic run; // start / stop
	} sadc_mode_t;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT_TRIG,
		ST_SAMPLE,
		ST_BIT,
		ST_DONE
	} sadc_state_t;
	typedef struct packed {
		logic [2:0] chan; // channel of the value
		logic [7:0] value; // converted code
	} sadc_result_t;
endpackage
`default_nettype wire

// *** verilog/sadc_sequencer.sv ***
// Summary of operation
// - successive approximation into 8-bit result register
// - eight inputs through mux, one at a time
// - conversion time about 30 us
// - hardware start on external trigger edge
// - software start by writing mode start bit
// - scan mode steps through inputs in turn
// - select mode converts one input repeatedly
// - mode register chooses source, mode, stop
// - done request except software-start select mode
// - done pulse usable for memory transfer service
// - mux starts on first input after reset
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module sadc_sequencer #(
	parameter int STEP_LEN = sadc_pkg::STEP_CYCLES
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// analog front end
	output logic [2:0] analog_inputs_sel,
	output logic analog_sample,
	output logic [7:0] dac_code,
	input wire logic comparator_hi,
	input wire logic ext_trigger_input,
	// events
	output logic conversion_done_irq,
	output logic irq
);
	import sadc_pkg::*;

	// ----------------------------------------
	// registers and state
	// ----------------------------------------
	sadc_mode_t converter_mode_reg; // software control
	sadc_result_t conversion_result_reg; // last finished value
	logic [1:0] ev_status; // sticky events
	logic [1:0] ev_mask; // interrupt enables
	sadc_state_t state; // sequencer state
	logic [15:0] step_cnt; // cycles left in a step
	logic [2:0] bit_idx; // bit under trial
	logic [7:0] trial; // successive approximation register
	logic [2:0] chan; // current mux channel
	logic trig_s1, trig_s2, trig_s3; // trigger synchroniser and edge
	logic cmp_s1, cmp_s2; // comparator synchroniser
	logic trig_edge; // rising edge of trigger
	logic done_pulse; // result written
	logic done_req; // done that raises the request
	logic step_end; // step counter expired

	// axi working signals
	logic aw_held, w_held; // address / data taken
	logic [7:0] wr_addr; // latched write address
	logic [31:0] wr_data; // latched write data
	logic [3:0] wr_strb; // latched byte enables
	logic wr_fire; // both halves present
	logic [31:0] next_rdata; // read mux

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	// two flops before use, third flop only for the edge
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			trig_s1 <= 1'b0;
			trig_s2 <= 1'b0;
			trig_s3 <= 1'b0;
			cmp_s1 <= 1'b0;
			cmp_s2 <= 1'b0;
		end else begin
			trig_s1 <= ext_trigger_input;
			trig_s2 <= trig_s1;
			trig_s3 <= trig_s2;
			cmp_s1 <= comparator_hi;
			cmp_s2 <= cmp_s1;
		end
	end

	assign trig_edge = trig_s2 && !trig_s3;

	// ----------------------------------------
	// axi write channel
	// ----------------------------------------
	// address and data taken in either order, one write at a time
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	assign s_axi_bresp = 2'h0;

	// capture address and data halves
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				wr_addr <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	// write response one cycle after both halves
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// mode register
	// ----------------------------------------
	// only byte lane 0 holds fields; upper lanes ignored
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			converter_mode_reg <= sadc_mode_t'(MODE_RST[5:0]);
		end else if (wr_fire && wr_addr == MODE_OFFS && wr_strb[0]) begin
			converter_mode_reg.run <= wr_data[MODE_RUN_POS];
			converter_mode_reg.hw_start <= wr_data[MODE_HW_POS];
			converter_mode_reg.scan <= wr_data[MODE_SCAN_POS];
			converter_mode_reg.chan <= wr_data[MODE_CHAN_POS +: 3];
		end
	end

	// ----------------------------------------
	// event status and mask
	// ----------------------------------------
	// hardware set wins over a same-cycle write-one-to-clear
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ev_status <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == EV_DONE_POS && done_req) || (i == EV_TRIG_POS && trig_edge)) begin
					ev_status[i] <= 1'b1;
				end else if (wr_fire && wr_addr == STAT_OFFS && wr_strb[0] && wr_data[i]) begin
					ev_status[i] <= 1'b0;
				end
			end
		end
	end

	// mask register
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ev_mask <= MASK_RST;
		end else if (wr_fire && wr_addr == MASK_OFFS && wr_strb[0]) begin
			ev_mask <= wr_data[1:0];
		end
	end

	assign irq = |(ev_status & ev_mask);

	// ----------------------------------------
	// axi read channel
	// ----------------------------------------
	// result register has no bus write path, only the sequencer writes it
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (s_axi_araddr)
			MODE_OFFS: next_rdata = {25'h0, converter_mode_reg.chan, 1'b0,
				converter_mode_reg.scan, converter_mode_reg.hw_start,
				converter_mode_reg.run};
			RESULT_OFFS: next_rdata = {21'h0, conversion_result_reg};
			STAT_OFFS: next_rdata = {30'h0, ev_status};
			MASK_OFFS: next_rdata = {30'h0, ev_mask};
			STATE_OFFS: next_rdata = {24'h0, 1'b0, chan, 1'b0, state};
			default: next_rdata = 32'h0000_0000; // unmapped reads zero
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;
	assign s_axi_rresp = 2'h0;

	// read data one cycle after address
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// step timer
	// ----------------------------------------
	assign step_end = step_cnt == 16'h0000;

	// reload at each step, conversion spans nine steps
	always_ff @(posedge ref_clk) begin
		if (sys_rst || state == ST_IDLE || state == ST_WAIT_TRIG || state == ST_DONE) begin
			step_cnt <= 16'(STEP_LEN - 1);
		end else if (step_end) begin
			step_cnt <= 16'(STEP_LEN - 1);
		end else begin
			step_cnt <= step_cnt - 16'h0001;
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	// stop by clearing run aborts at once
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			chan <= CHAN_RST;
			bit_idx <= 3'h7;
			trial <= 8'h00;
		end else if (!converter_mode_reg.run) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				// wait for a start source
				ST_IDLE: begin
					if (converter_mode_reg.hw_start) begin
						state <= ST_WAIT_TRIG;
					end else begin
						state <= ST_SAMPLE;
						chan <= converter_mode_reg.scan ? 3'h0 : converter_mode_reg.chan;
					end
				end
				// armed, external trigger starts conversion
				ST_WAIT_TRIG: begin
					if (trig_edge) begin
						state <= ST_SAMPLE;
						chan <= converter_mode_reg.scan ? 3'h0 : converter_mode_reg.chan;
					end
				end
				// mux settles on the channel
				ST_SAMPLE: begin
					bit_idx <= 3'h7;
					trial <= 8'h80;
					if (step_end) begin
						state <= ST_BIT;
					end
				end
				// keep or drop the trial bit
				ST_BIT: begin
					if (step_end) begin
						trial[bit_idx] <= cmp_s2;
						if (bit_idx == 3'h0) begin
							state <= ST_DONE;
						end else begin
							trial[bit_idx - 3'h1] <= 1'b1;
							bit_idx <= bit_idx - 3'h1;
						end
					end
				end
				// result written, pick next channel
				ST_DONE: begin
					state <= ST_SAMPLE;
					if (converter_mode_reg.scan) begin
						// wrap to first input after last
						chan <= (chan >= converter_mode_reg.chan) ? 3'h0 : chan + 3'h1;
					end else begin
						chan <= converter_mode_reg.chan;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// result and completion request
	// ----------------------------------------
	assign done_pulse = state == ST_DONE && converter_mode_reg.run;
	// no request in software-start select mode
	assign done_req = done_pulse && (converter_mode_reg.hw_start || converter_mode_reg.scan);

	// result transfer
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			conversion_result_reg <= '0;
		end else if (done_pulse) begin
			conversion_result_reg.value <= trial;
			conversion_result_reg.chan <= chan;
		end
	end

	// one-cycle pulse for the transfer service
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			conversion_done_irq <= 1'b0;
		end else begin
			conversion_done_irq <= done_req;
		end
	end

	// ----------------------------------------
	// analog front end drive
	// ----------------------------------------
	// mux follows the current channel
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			analog_inputs_sel <= CHAN_RST;
			analog_sample <= 1'b0;
			dac_code <= 8'h00;
		end else begin
			analog_inputs_sel <= chan;
			analog_sample <= state == ST_SAMPLE;
			dac_code <= trial;
		end
	end
endmodule
`default_nettype wire
